// File: shared/agc_pkg.sv
/*
  Constants, widths and conversion functions shared by the receive gain
  control decision logic and its counters.
  Assumes one instance per receive channel on the receiver sample clock.
*/
`default_nettype none

package agc_pkg;

  // widths
  localparam int SAMP_W   = 16;
  localparam int GAIN_W   = 8;
  localparam int STEP_W   = 5;
  localparam int CNT_W    = 10;
  localparam int PERIOD_W = 22;
  localparam int MV_W     = 10;
  localparam int DB_W     = 5;
  localparam int PWR_W    = 16;
  localparam int ACC_W    = 48;

  // full scale: peak voltage and matching magnitude code
  localparam logic [31:0]       FULL_SCALE_MV = 32'd707;
  localparam logic [SAMP_W-1:0] FULL_CODE     = 16'h7fff;

  // power estimate is the period sum of squares shifted down by this
  localparam int PWR_SHIFT = 24;

  // reset values
  localparam logic [GAIN_W-1:0]   GAIN_INDEX_RESET = 8'hff;
  localparam logic [PERIOD_W-1:0] PERIOD_RESET     = 22'h000000;
  localparam logic [CNT_W-1:0]    COUNT_RESET      = 10'h000;
  localparam logic [PWR_W-1:0]    POWER_RESET      = 16'h0000;

  // power tap selection codes
  localparam logic [1:0] TAP_HALFBAND  = 2'h0;
  localparam logic [1:0] TAP_RX_FILTER = 2'h1;
  localparam logic [1:0] TAP_DC_CORR   = 2'h2;

  // peak voltage threshold in mV to magnitude code
  function automatic logic [SAMP_W-1:0] mv_to_code(input logic [MV_W-1:0] mv);
    logic [31:0] p;
    p = (32'(mv) * 32'(FULL_CODE)) / FULL_SCALE_MV;
    return (p > 32'(FULL_CODE)) ? FULL_CODE : p[SAMP_W-1:0];
  endfunction

  // threshold in -dBFS to magnitude code: 6 dB per shift, table for the rest
  function automatic logic [SAMP_W-1:0] db_to_code(input logic [DB_W-1:0] db);
    logic [2:0]        rem;
    logic [2:0]        sh;
    logic [SAMP_W-1:0] base;
    rem = 3'(db % 5'd6);
    sh  = 3'(db / 5'd6);
    unique case (rem)
      3'h0: base = 16'h7fff;
      3'h1: base = 16'h7214;
      3'h2: base = 16'h65ac;
      3'h3: base = 16'h5a9d;
      3'h4: base = 16'h50c3;
      default: base = 16'h47fb;
    endcase
    return base >> sh;
  endfunction

endpackage

`default_nettype wire

// File: shared/exceed_if.sv
/*
  Link between the decision logic and one threshold-exceeded sample counter.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

interface exceed_if;
  logic                      hit;     // sample above threshold this cycle
  logic                      clear;   // restart count
  logic [agc_pkg::CNT_W-1:0] limit;   // programmed exceeded count
  logic [agc_pkg::CNT_W-1:0] count;
  logic                      reached; // count has reached limit

  modport counter (input hit, clear, limit, output count, reached);
  modport user    (output hit, clear, limit, input count, reached);
endinterface

`default_nettype wire

// File: src/exceed_counter.sv
/*
  Counts samples above one threshold and flags when the programmed
  exceeded count is reached.
  Assumes hit is already qualified by the sample strobe.
*/
`timescale 1ns/100ps
`default_nettype none

module exceed_counter
(
  // clock and reset
  input  wire logic clock,
  input  wire logic srst,
  // counter link
  exceed_if.counter cnt
);

  logic [agc_pkg::CNT_W-1:0] count_reg;
  logic [agc_pkg::CNT_W-1:0] count_next;

  // clear wins; count saturates once the limit is reached
  always_comb
  begin
    count_next = count_reg;
    if (cnt.clear)
      count_next = agc_pkg::COUNT_RESET;
    else if (cnt.hit && !cnt.reached)
      count_next = count_reg + 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      count_reg <= agc_pkg::COUNT_RESET;
    else
      count_reg <= count_next;
  end

  assign cnt.count   = count_reg;
  assign cnt.reached = (count_reg >= cnt.limit);

endmodule

`default_nettype wire

// File: src/power_detector.sv
/*
  Digital power estimate: sum of squares of the selected tap over one
  update period, latched and restarted at each period expiry.
  Assumes samples are signed and qualified by sample_valid.
*/
`timescale 1ns/100ps
`default_nettype none

module power_detector
(
  // clock and reset
  input  wire logic                            clock,
  input  wire logic                            srst,
  // taps
  input  wire logic                            sample_valid,
  input  wire logic signed [agc_pkg::SAMP_W-1:0] halfband_sample,
  input  wire logic signed [agc_pkg::SAMP_W-1:0] rx_filter_sample,
  input  wire logic signed [agc_pkg::SAMP_W-1:0] dc_corr_sample,
  input  wire logic [1:0]                      power_tap_select,
  // period and result
  input  wire logic                            expiry,
  output logic [agc_pkg::PWR_W-1:0]            power_level
);

  logic signed [agc_pkg::SAMP_W-1:0] tap;
  logic [31:0]                       square;
  logic [agc_pkg::ACC_W-1:0]         acc_reg;
  logic [agc_pkg::ACC_W-1:0]         acc_next;
  logic [agc_pkg::ACC_W-1:0]         scaled;
  logic [agc_pkg::PWR_W-1:0]         level_reg;
  logic [agc_pkg::PWR_W-1:0]         level_next;

  // tap select, square, accumulate, latch at expiry
  always_comb
  begin
    unique case (power_tap_select)
      agc_pkg::TAP_RX_FILTER: tap = rx_filter_sample; // RULE16
      agc_pkg::TAP_DC_CORR:   tap = dc_corr_sample;
      default:                tap = halfband_sample;
    endcase
    square     = 32'(tap * tap);
    scaled     = acc_reg >> agc_pkg::PWR_SHIFT;
    level_next = level_reg;
    acc_next   = acc_reg;
    if (sample_valid)
      acc_next = acc_reg + agc_pkg::ACC_W'(square);
    if (expiry)
    begin
      acc_next   = sample_valid ? agc_pkg::ACC_W'(square) : '0; // expiry sample opens the new period
      level_next = (scaled > agc_pkg::ACC_W'(16'hffff)) ? 16'hffff : scaled[agc_pkg::PWR_W-1:0];
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      acc_reg   <= '0;
      level_reg <= agc_pkg::POWER_RESET;
    end
    else
    begin
      acc_reg   <= acc_next;
      level_reg <= level_next;
    end
  end

  assign power_level = level_reg;

endmodule

`default_nettype wire

// File: src/rx_agc_detector_gain_logic.sv
/*
  Receive gain control decision logic for one channel: peak, half-band and
  power detectors steer the gain index down (attack) or up (recovery).
  Assumes all inputs come from logic on the same sample clock and that the
  configuration ports are held steady while running.
  // How it works
  // RULE1: peak high count reached steps gain down
  // RULE2: peak fast attack acts at once, else expiry
  // RULE3: peak decrement skipped below minimum gain index
  // RULE4: too few peak low hits raises gain
  // RULE5: increment skipped above maximum gain index
  // RULE6: any gain change clears all peak counters
  // RULE7: update period counter ignores gain changes
  // RULE8: peak thresholds in mV, 707 mV full scale
  // RULE9: half-band detector can be switched off
  // RULE10: half-band thresholds high, low, very low in -dBFS
  // RULE11: half-band high count reached steps gain down
  // RULE12: half-band fast attack timing and limit check
  // RULE13: too few half-band low hits raises gain
  // RULE14: too few very low hits raises gain
  // RULE15: software makes very low step larger
  // RULE16: power measured at selectable tap
  // RULE17: software orders power thresholds descending
  // RULE18: power above upper thresholds steps gain down
  // RULE19: power decrements only at period expiry
  // RULE20: power below lower thresholds raises gain
  // RULE21: software gives outer thresholds larger steps
  // RULE22: attack priority peak, half-band, upper high, upper low
  // RULE23: recovery priority very low, peak, half-band, lower low, lower high
  // RULE24: software zeroes peak steps for power only
  // RULE25: period counter reloads and strobes expiry
  // RULE26: one highest-priority change per decision instant
*/
`timescale 1ns/100ps
`default_nettype none

module rx_agc_detector_gain_logic
(
  // clock and reset
  input  wire logic                                clock,
  input  wire logic                                srst,
  // detector data
  input  wire logic                                sample_valid,
  input  wire logic [agc_pkg::SAMP_W-1:0]          peak_level,
  input  wire logic signed [agc_pkg::SAMP_W-1:0]   halfband_sample,
  input  wire logic signed [agc_pkg::SAMP_W-1:0]   rx_filter_sample,
  input  wire logic signed [agc_pkg::SAMP_W-1:0]   dc_corr_sample,
  // analog peak detector setup
  input  wire logic [agc_pkg::MV_W-1:0]            peak_high_threshold,
  input  wire logic [agc_pkg::MV_W-1:0]            peak_low_threshold,
  input  wire logic [agc_pkg::CNT_W-1:0]           peak_high_exceed_count,
  input  wire logic [agc_pkg::CNT_W-1:0]           peak_low_exceed_count,
  input  wire logic [agc_pkg::STEP_W-1:0]          peak_attack_step,
  input  wire logic [agc_pkg::STEP_W-1:0]          peak_recovery_step,
  input  wire logic                                peak_fast_attack,
  // half-band overload detector setup
  input  wire logic                                halfband_detect_on,
  input  wire logic [agc_pkg::DB_W-1:0]            halfband_high_threshold,
  input  wire logic [agc_pkg::DB_W-1:0]            halfband_low_threshold,
  input  wire logic [agc_pkg::DB_W-1:0]            halfband_verylow_threshold,
  input  wire logic [agc_pkg::CNT_W-1:0]           halfband_high_exceed_count,
  input  wire logic [agc_pkg::CNT_W-1:0]           halfband_low_exceed_count,
  input  wire logic [agc_pkg::CNT_W-1:0]           halfband_verylow_exceed_count,
  input  wire logic [agc_pkg::STEP_W-1:0]          halfband_attack_step,
  input  wire logic [agc_pkg::STEP_W-1:0]          halfband_recovery_step,
  input  wire logic [agc_pkg::STEP_W-1:0]          halfband_verylow_step,
  input  wire logic                                halfband_fast_attack,
  // power measure detector setup
  input  wire logic [1:0]                          power_tap_select,
  input  wire logic [agc_pkg::PWR_W-1:0]           power_upper_high_threshold,
  input  wire logic [agc_pkg::PWR_W-1:0]           power_upper_low_threshold,
  input  wire logic [agc_pkg::PWR_W-1:0]           power_lower_high_threshold,
  input  wire logic [agc_pkg::PWR_W-1:0]           power_lower_low_threshold,
  input  wire logic [agc_pkg::STEP_W-1:0]          power_upper_high_step,
  input  wire logic [agc_pkg::STEP_W-1:0]          power_upper_low_step,
  input  wire logic [agc_pkg::STEP_W-1:0]          power_lower_high_step,
  input  wire logic [agc_pkg::STEP_W-1:0]          power_lower_low_step,
  input  wire logic                                peak_only_select,
  // gain limits and period
  input  wire logic [agc_pkg::PERIOD_W-1:0]        gain_update_period,
  input  wire logic [agc_pkg::GAIN_W-1:0]          ch1_min_gain_index,
  input  wire logic [agc_pkg::GAIN_W-1:0]          ch1_max_gain_index,
  // results
  output logic [agc_pkg::GAIN_W-1:0]               gain_index,
  output logic                                     gain_changed,
  output logic                                     gain_rise,
  output logic [agc_pkg::PWR_W-1:0]                power_level
);

  localparam int GW = agc_pkg::GAIN_W + 1;

  exceed_if pk_hi_if ();
  exceed_if pk_lo_if ();
  exceed_if hb_hi_if ();
  exceed_if hb_lo_if ();
  exceed_if hb_vl_if ();

  logic [agc_pkg::PERIOD_W-1:0] period_reg;
  logic [agc_pkg::PERIOD_W-1:0] period_next;
  logic                         expiry;
  logic [agc_pkg::GAIN_W-1:0]   gain_reg;
  logic [agc_pkg::GAIN_W-1:0]   gain_next;
  logic                         changed_reg;
  logic                         rise_reg;
  logic [agc_pkg::SAMP_W-1:0]   hb_mag;
  logic                         hb_valid;
  logic                         pk_atk;
  logic                         hb_atk;
  logic                         pw_uh;
  logic                         pw_ul;
  logic                         hb_vl_rec;
  logic                         pk_rec;
  logic                         hb_lo_rec;
  logic                         pw_ll;
  logic                         pw_lh;
  logic                         dec_req;
  logic                         inc_req;
  logic [agc_pkg::STEP_W-1:0]   dec_step;
  logic [agc_pkg::STEP_W-1:0]   inc_step;
  logic                         dec_ok;
  logic                         inc_ok;
  logic                         chg_dec;
  logic                         chg_inc;
  logic                         chg;

  // magnitude of a signed sample
  function automatic logic [agc_pkg::SAMP_W-1:0] magnitude(input logic signed [agc_pkg::SAMP_W-1:0] s);
    return s[agc_pkg::SAMP_W-1] ? agc_pkg::SAMP_W'(-s) : agc_pkg::SAMP_W'(s);
  endfunction

  // update period counter: free running, reload on expiry
  always_comb
  begin
    expiry      = (period_reg == '0);                                           // RULE25
    period_next = expiry ? gain_update_period : period_reg - 1'b1;              // RULE7
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      period_reg <= agc_pkg::PERIOD_RESET;
    else
      period_reg <= period_next;
  end

  // sample counters: hits against converted thresholds
  assign hb_mag   = magnitude(halfband_sample);
  assign hb_valid = sample_valid && halfband_detect_on;                          // RULE9
  assign pk_hi_if.hit = sample_valid && (peak_level > agc_pkg::mv_to_code(peak_high_threshold)); // RULE8
  assign pk_lo_if.hit = sample_valid && (peak_level > agc_pkg::mv_to_code(peak_low_threshold));
  assign hb_hi_if.hit = hb_valid && (hb_mag > agc_pkg::db_to_code(halfband_high_threshold)); // RULE10
  assign hb_lo_if.hit = hb_valid && (hb_mag > agc_pkg::db_to_code(halfband_low_threshold));
  assign hb_vl_if.hit = hb_valid && (hb_mag > agc_pkg::db_to_code(halfband_verylow_threshold));
  assign pk_hi_if.limit = peak_high_exceed_count;
  assign pk_lo_if.limit = peak_low_exceed_count;
  assign hb_hi_if.limit = halfband_high_exceed_count;
  assign hb_lo_if.limit = halfband_low_exceed_count;
  assign hb_vl_if.limit = halfband_verylow_exceed_count;
  // counters restart each period and on every gain change
  assign pk_hi_if.clear = expiry || chg;                                         // RULE6
  assign pk_lo_if.clear = expiry || chg;
  assign hb_hi_if.clear = expiry || chg;
  assign hb_lo_if.clear = expiry || chg;
  assign hb_vl_if.clear = expiry || chg;

  exceed_counter u_pk_hi (.clock(clock), .srst(srst), .cnt(pk_hi_if));
  exceed_counter u_pk_lo (.clock(clock), .srst(srst), .cnt(pk_lo_if));
  exceed_counter u_hb_hi (.clock(clock), .srst(srst), .cnt(hb_hi_if));
  exceed_counter u_hb_lo (.clock(clock), .srst(srst), .cnt(hb_lo_if));
  exceed_counter u_hb_vl (.clock(clock), .srst(srst), .cnt(hb_vl_if));

  power_detector u_power
  (
    .clock            (clock),
    .srst             (srst),
    .sample_valid     (sample_valid),
    .halfband_sample  (halfband_sample),
    .rx_filter_sample (rx_filter_sample),
    .dc_corr_sample   (dc_corr_sample),
    .power_tap_select (power_tap_select),
    .expiry           (expiry),
    .power_level      (power_level)
  );

  // overrange and underrange conditions; a zero peak or half-band step never claims priority, a zero power step still does
  always_comb
  begin
    pk_atk    = pk_hi_if.reached && (peak_fast_attack || expiry) && (peak_attack_step != '0); // RULE1 RULE2
    hb_atk    = halfband_detect_on && hb_hi_if.reached && (halfband_fast_attack || expiry)
                && (halfband_attack_step != '0);                                // RULE11 RULE12
    pw_uh     = expiry && !peak_only_select && (power_level > power_upper_high_threshold); // RULE18 RULE19
    pw_ul     = expiry && !peak_only_select && (power_level > power_upper_low_threshold);
    hb_vl_rec = expiry && halfband_detect_on && !hb_vl_if.reached && (halfband_verylow_step != '0); // RULE14
    pk_rec    = expiry && !pk_lo_if.reached && (peak_recovery_step != '0);      // RULE4
    hb_lo_rec = expiry && halfband_detect_on && !hb_lo_if.reached && (halfband_recovery_step != '0); // RULE13
    pw_ll     = expiry && !peak_only_select && (power_level < power_lower_low_threshold); // RULE20
    pw_lh     = expiry && !peak_only_select && (power_level < power_lower_high_threshold);
  end

  // priority selection of the single step
  always_comb
  begin
    dec_req  = 1'b1;
    dec_step = '0;
    if (pk_atk)                                                                  // RULE22
      dec_step = peak_attack_step;
    else if (hb_atk)
      dec_step = halfband_attack_step;
    else if (pw_uh)
      dec_step = power_upper_high_step;
    else if (pw_ul)
      dec_step = power_upper_low_step;
    else
      dec_req = 1'b0;
    inc_req  = 1'b1;
    inc_step = '0;
    if (hb_vl_rec)                                                               // RULE23
      inc_step = halfband_verylow_step;
    else if (pk_rec)
      inc_step = peak_recovery_step;
    else if (hb_lo_rec)
      inc_step = halfband_recovery_step;
    else if (pw_ll)
      inc_step = power_lower_low_step;
    else if (pw_lh)
      inc_step = power_lower_high_step;
    else
      inc_req = 1'b0;
  end

  // limit checks and gain update, attack beats recovery
  always_comb
  begin
    dec_ok    = (GW'(gain_reg) >= GW'(ch1_min_gain_index) + GW'(dec_step));    // RULE3 RULE12
    inc_ok    = (GW'(gain_reg) + GW'(inc_step) <= GW'(ch1_max_gain_index));    // RULE5
    chg_dec   = dec_req && dec_ok;
    chg_inc   = !dec_req && inc_req && inc_ok;                                   // RULE26
    chg       = chg_dec || chg_inc;
    gain_next = gain_reg;
    if (chg_dec)
      gain_next = gain_reg - agc_pkg::GAIN_W'(dec_step);
    else if (chg_inc)
      gain_next = gain_reg + agc_pkg::GAIN_W'(inc_step);
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      gain_reg    <= agc_pkg::GAIN_INDEX_RESET;
      changed_reg <= 1'b0;
      rise_reg    <= 1'b0;
    end
    else
    begin
      gain_reg    <= gain_next;
      changed_reg <= chg;
      rise_reg    <= chg_inc;
    end
  end

  assign gain_index   = gain_reg;
  assign gain_changed = changed_reg;
  assign gain_rise    = rise_reg;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  chk_peak_fast_atk: assert property ( // RULE1
    (peak_fast_attack && pk_hi_if.reached && peak_attack_step != '0 && dec_ok)
    |=> gain_index == $past(gain_index) - agc_pkg::GAIN_W'($past(peak_attack_step)))
    else $error("peak fast attack did not step gain down");

  chk_slow_wait: assert property ( // RULE2
    (!peak_fast_attack && !halfband_fast_attack && !expiry) |=> $stable(gain_index))
    else $error("gain moved between expiries without fast attack");

  chk_dec_floor: assert property ( // RULE3
    (dec_req && !dec_ok) |=> $stable(gain_index) && !gain_changed)
    else $error("decrement below minimum was not skipped");

  chk_inc_ceiling: assert property ( // RULE5
    (!dec_req && inc_req && !inc_ok) |=> $stable(gain_index))
    else $error("increment above maximum was not skipped");

  chk_counter_clear: assert property ( // RULE6
    chg |=> pk_hi_if.count == '0 && hb_hi_if.count == '0 && hb_vl_if.count == '0)
    else $error("peak counters not cleared on gain change");

  chk_period_runs: assert property ( // RULE7
    (chg && !expiry) |=> period_reg == $past(period_reg) - 1'b1)
    else $error("period counter disturbed by gain change");

  chk_period_reload: assert property ( // RULE25
    expiry |=> period_reg == $past(gain_update_period))
    else $error("period counter did not reload");

  chk_rise_expiry: assert property ( // RULE4
    gain_rise |-> $past(expiry) && gain_changed && gain_index > $past(gain_index))
    else $error("gain rose outside an expiry");

  chk_hb_off: assert property ( // RULE9
    (!halfband_detect_on && !expiry && !chg) |=> hb_hi_if.count == $past(hb_hi_if.count))
    else $error("disabled half-band detector counted");

  chk_power_upper: assert property ( // RULE18
    (pw_uh && !pk_atk && !hb_atk && dec_ok)
    |=> gain_index == $past(gain_index) - agc_pkg::GAIN_W'($past(power_upper_high_step)))
    else $error("power upper high step not applied");

  cov_fast_attack: cover property (peak_fast_attack && !expiry && chg_dec);
  cov_recovery:    cover property (expiry ##1 gain_rise);
  cov_power_dec:   cover property (pw_ul && !pw_uh && chg_dec);
  cov_skip:        cover property (dec_req && !dec_ok);

endmodule

`default_nettype wire

// File: test/frontend_model.sv
/*
  Behavioural receive front end: one peak magnitude and three signed taps.
  Assumes the bench sets the amplitudes by non-blocking assignment.
*/
`timescale 1ns/100ps
`default_nettype none

module frontend_model
(
  // clock and reset
  input  wire logic          clock,
  input  wire logic          srst,
  // wanted amplitudes
  input  wire logic [15:0]   peak_amp,
  input  wire logic [15:0]   hb_amp,
  // samples
  output logic               sample_valid,
  output logic [15:0]        peak_level,
  output logic signed [15:0] halfband_sample,
  output logic signed [15:0] rx_filter_sample,
  output logic signed [15:0] dc_corr_sample
);
  logic sign_reg;

  // sign flips each sample so a tap never holds one value
  always_ff @(posedge clock)
  begin
    sign_reg <= srst ? 1'b0 : !sign_reg;
  end

  // filter tap at half and dc tap at a quarter of the half-band amplitude
  always_comb
  begin
    sample_valid = !srst;
    peak_level = peak_amp;
    halfband_sample = sign_reg ? -$signed(hb_amp) : $signed(hb_amp);
    rx_filter_sample = sign_reg ? -$signed(hb_amp >> 1) : $signed(hb_amp >> 1);
    dc_corr_sample = sign_reg ? -$signed(hb_amp >> 2) : $signed(hb_amp >> 2);
  end
endmodule

`default_nettype wire

// File: test/test_rx_agc_detector_gain_logic.sv
/*
  Self-checking bench: table of detector set-ups and the gain index each
  should reach, then tap and reset checks. Assumes agc_pkg and the model.
*/
`timescale 1ns/100ps
`default_nettype none

module test_rx_agc_detector_gain_logic;
  typedef struct {
    logic [15:0] pk, hb;
    logic [4:0]  pa, pr, ha, hr, hv, pu;
    logic [1:0]  fa;
    logic        on, sync;
    logic [7:0]  gain;
  } row_t;
  logic        clock, srst, sample_valid, peak_fast_attack, halfband_fast_attack;
  logic        halfband_detect_on, peak_only_select, gain_changed, gain_rise;
  logic [15:0] peak_amp, hb_amp, peak_level, power_level, power_upper_high_threshold;
  logic [15:0] power_upper_low_threshold, power_lower_high_threshold, power_lower_low_threshold;
  logic signed [15:0] halfband_sample, rx_filter_sample, dc_corr_sample;
  logic [9:0]  peak_high_threshold, peak_low_threshold, peak_high_exceed_count, peak_low_exceed_count;
  logic [9:0]  halfband_high_exceed_count, halfband_low_exceed_count, halfband_verylow_exceed_count;
  logic [4:0]  halfband_high_threshold, halfband_low_threshold, halfband_verylow_threshold;
  logic [4:0]  peak_attack_step, peak_recovery_step, halfband_attack_step, halfband_recovery_step;
  logic [4:0]  halfband_verylow_step, power_upper_high_step, power_upper_low_step;
  logic [4:0]  power_lower_high_step, power_lower_low_step;
  logic [1:0]  power_tap_select;
  logic [21:0] gain_update_period;
  logic [7:0]  ch1_min_gain_index, ch1_max_gain_index, gain_index, cur;
  int          bad_count, checks_done, cyc, ref_cyc, n;
  // peak, half-band, steps pa pr ha hr hv pu, fast, on, aligned, gain
  row_t rows[14] = '{
    '{16'h7000, 16'h0000, 5'h04, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 2'h0, 1'b1, 1'b1, 8'hfb},
    '{16'h7000, 16'h0000, 5'h04, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 2'h1, 1'b1, 1'b0, 8'hf7},
    '{16'h0100, 16'h0000, 5'h00, 5'h02, 5'h00, 5'h00, 5'h00, 5'h00, 2'h0, 1'b1, 1'b1, 8'hf9},
    '{16'h3000, 16'h4000, 5'h00, 5'h00, 5'h03, 5'h00, 5'h00, 5'h00, 2'h2, 1'b1, 1'b0, 8'hf6},
    '{16'h3000, 16'h0800, 5'h00, 5'h00, 5'h00, 5'h01, 5'h05, 5'h00, 2'h0, 1'b1, 1'b1, 8'hfb},
    '{16'h3000, 16'h1800, 5'h00, 5'h00, 5'h00, 5'h01, 5'h05, 5'h00, 2'h0, 1'b1, 1'b1, 8'hfc},
    '{16'h7000, 16'h4000, 5'h02, 5'h00, 5'h06, 5'h00, 5'h00, 5'h00, 2'h0, 1'b1, 1'b1, 8'hfa},
    '{16'h7000, 16'h0000, 5'h0b, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 2'h1, 1'b1, 1'b0, 8'hfa},
    '{16'h3000, 16'h4000, 5'h00, 5'h00, 5'h03, 5'h00, 5'h00, 5'h00, 2'h2, 1'b0, 1'b0, 8'hfa},
    '{16'h3000, 16'h4000, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h02, 2'h0, 1'b1, 1'b1, 8'hf8},
    '{16'h0100, 16'h4000, 5'h00, 5'h06, 5'h00, 5'h00, 5'h00, 5'h00, 2'h0, 1'b1, 1'b0, 8'hf8},
    '{16'h5a85, 16'h0000, 5'h01, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 2'h1, 1'b1, 1'b0, 8'hf8},
    '{16'h5a86, 16'h0000, 5'h01, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 2'h1, 1'b1, 1'b0, 8'hf7},
    '{16'h3000, 16'h4000, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 2'h0, 1'b1, 1'b0, 8'hf7}};

  rx_agc_detector_gain_logic i_rx_agc_detector_gain_logic (.*);
  frontend_model i_frontend_model (.*);

  // 100 MHz clock and a free cycle count
  initial
  begin
    clock = 1'b0;
    forever #5 clock = !clock;
  end
  always @(posedge clock) cyc <= cyc + 1;

  task automatic fail(string m);
    bad_count++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task automatic cmp_gain(logic [7:0] g, logic [7:0] e);
    checks_done++;
    if (g !== e) fail("gain index");
  endtask
  task automatic cmp_bit(logic g, logic e);
    checks_done++;
    if (g !== e) fail("flag or timing");
  endtask
  task automatic cmp_pwr(logic [15:0] g, logic [15:0] e);
    checks_done++;
    if (g !== e) fail("power level");
  endtask
  task automatic close_out;
    if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_reset;
    cmp_gain(gain_index, 8'hff);
    cmp_bit(gain_changed, 1'b0);
    cmp_bit(gain_rise, 1'b0);
    cmp_pwr(power_level, 16'h0000);
  endtask
  // one row of detector set-up, applied on a rising edge
  task automatic apply(row_t r);
    @(posedge clock);
    {peak_amp, hb_amp} <= {r.pk, r.hb};
    {peak_attack_step, peak_recovery_step, halfband_attack_step} <= {r.pa, r.pr, r.ha};
    {halfband_recovery_step, halfband_verylow_step, power_upper_high_step} <= {r.hr, r.hv, r.pu};
    {peak_fast_attack, halfband_fast_attack, halfband_detect_on} <= {r.fa[0], r.fa[1], r.on};
    peak_only_select <= (r.pu == 5'h00);
    #1;
  endtask

  initial
  begin
    srst = 1'b1;
    {peak_amp, hb_amp, power_tap_select, peak_only_select} = {16'h0000, 16'h0000, 2'h0, 1'b1};
    {peak_fast_attack, halfband_fast_attack, halfband_detect_on} = 3'h0;
    {peak_attack_step, peak_recovery_step, halfband_attack_step, halfband_recovery_step} = 20'h00000;
    {halfband_verylow_step, power_upper_high_step} = 10'h000;
    {power_upper_low_step, power_lower_high_step, power_lower_low_step} = {5'h01, 5'h01, 5'h03};
    {peak_high_threshold, peak_low_threshold} = {10'h1f4, 10'h064};
    {peak_high_exceed_count, peak_low_exceed_count} = {10'h002, 10'h002};
    {halfband_high_exceed_count, halfband_low_exceed_count, halfband_verylow_exceed_count} = {3{10'h002}};
    {halfband_high_threshold, halfband_low_threshold, halfband_verylow_threshold} = {5'h06, 5'h0c, 5'h12};
    {power_upper_high_threshold, power_upper_low_threshold} = {16'h0080, 16'h0040};
    {power_lower_high_threshold, power_lower_low_threshold} = {16'h0008, 16'h0004};
    {gain_update_period, ch1_min_gain_index, ch1_max_gain_index} = {22'h00000f, 8'hf0, 8'hfd};
    repeat (10) @(posedge clock);
    #1;
    chk_reset;
    @(posedge clock) srst <= 1'b0;
    // rows 0 to 12: wait for one gain change, or prove that none comes
    for (int i = 0; i < 13; i++)
    begin
      apply(rows[i]);
      cur = gain_index;
      n = 0;
      while (n < 40 && gain_changed !== 1'b1)
      begin
        @(posedge clock);
        #1;
        n++;
      end
      if (rows[i].gain === cur) cmp_bit(gain_changed, 1'b0);
      else
      begin
        cmp_bit(gain_changed, 1'b1);
        if (gain_changed !== 1'b1) close_out;
        cmp_gain(gain_index, rows[i].gain);
        cmp_bit(gain_rise, rows[i].gain > cur);
        if (i == 0) ref_cyc = cyc;
        else if (rows[i].sync) cmp_bit((cyc - ref_cyc) % 16 == 0, 1'b1);
        else cmp_bit(n < 8, 1'b1);
      end
    end
    // power estimate at every tap code
    apply(rows[13]);
    for (int t = 0; t < 4; t++)
    begin
      @(posedge clock);
      power_tap_select <= 2'(t);
      repeat (40) @(posedge clock);
      #1;
      cmp_pwr(power_level, 16'h0100 >> (2 * (t % 3)));
    end
    // second reset in mid-run
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk_reset;
    close_out;
  end
endmodule

`default_nettype wire
